/* File: logic/pwm_channel_control_regs.v */
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "pwm_ctrl_map.vh"

module pwm_channel_control_regs (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [11:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // Waveforms and interrupt
  output wire [`NUM_CH-1:0] pwm_o,
  output wire irq_o
);

  reg [31:0] global_mode;
  reg [`NUM_CH-1:0] ch_en;
  reg [`NUM_CH-1:0] irq_mask;
  reg [`NUM_CH-1:0] irq_flag;
  reg [`CM_WIDTH-1:0] ch_mode [0:`NUM_CH-1];
  reg [`CNT_W-1:0] ch_duty [0:`NUM_CH-1];
  reg [`CNT_W-1:0] ch_period [0:`NUM_CH-1];
  reg [`CNT_W-1:0] ch_upd [0:`NUM_CH-1];
  reg [`NUM_CH-1:0] upd_pend;
  reg [9:0] pre_cnt;
  reg [7:0] div_a_cnt;
  reg [7:0] div_b_cnt;
  wire [`NUM_CH-1:0] period_end;
  wire [`NUM_CH-1:0] start;
  wire [`CNT_W-1:0] cnt_w [0:`NUM_CH-1];
  wire [10:0] pre_tick;
  wire tick_a;
  wire tick_b;
  wire req;
  wire wr;
  wire rd;
  wire ch_sel;
  wire [1:0] ch_idx;
  wire [2:0] ch_ofs;
  wire [31:0] wmask;
  wire [31:0] wdat;
  reg [31:0] next_dat;

  assign req = cyc_i && stb_i && !ack_o;
  assign wr = req && we_i;
  assign rd = req && !we_i;
  assign ch_sel = (adr_i[11:7] == 5'h04);
  assign ch_idx = adr_i[6:5];
  assign ch_ofs = adr_i[4:2];
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}},
    {8{sel_i[0]}}};
  assign wdat = dat_i & wmask;
  assign start = (wr && adr_i == `ADDR_OUT_ENABLE) ?
    wdat[`NUM_CH-1:0] : {`NUM_CH{1'b0}};

  // Shared prescaler: bit k toggles once per 2^k clocks
  always @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt <= 10'h000;
    end else begin
      pre_cnt <= pre_cnt + 10'h001;
    end
  end

  genvar k;
  generate
    for (k = 0; k < 11; k = k + 1) begin : g_pre
      if (k == 0) begin : g_zero
        assign pre_tick[k] = 1'b1;
      end else begin : g_div
        assign pre_tick[k] = (pre_cnt[k-1:0] == {k{1'b1}});
      end
    end
  endgenerate

  // Divided clocks A and B from selected prescaler tap
  wire [3:0] pre_a = global_mode[`GM_PREA_LSB +: 4];
  wire [3:0] pre_b = global_mode[`GM_PREB_LSB +: 4];
  wire [7:0] div_a = global_mode[`GM_DIVA_LSB +: 8];
  wire [7:0] div_b = global_mode[`GM_DIVB_LSB +: 8];
  wire src_a = (pre_a <= `PRE_MAX_POW) && pre_tick[pre_a];
  wire src_b = (pre_b <= `PRE_MAX_POW) && pre_tick[pre_b];
  assign tick_a = src_a && (div_a != 8'h00) && (div_a_cnt == 8'h00);
  assign tick_b = src_b && (div_b != 8'h00) && (div_b_cnt == 8'h00);

  always @(posedge clk_i) begin
    if (rst_i) begin
      div_a_cnt <= 8'h00;
      div_b_cnt <= 8'h00;
    end else begin
      if (src_a) begin
        div_a_cnt <= (div_a_cnt == 8'h00) ? div_a - 8'h01 :
          div_a_cnt - 8'h01;
      end
      if (src_b) begin
        div_b_cnt <= (div_b_cnt == 8'h00) ? div_b - 8'h01 :
          div_b_cnt - 8'h01;
      end
    end
  end

  // Per-channel counter, update buffer and registers
  genvar c;
  generate
    for (c = 0; c < `NUM_CH; c = c + 1) begin : g_ch
      wire [3:0] cs = ch_mode[c][`CM_PRE_LSB +: 4];
      wire tick = (cs <= `PRE_MAX_POW) ? pre_tick[cs] :
        (cs == `PRE_CLK_A) ? tick_a :
        (cs == `PRE_CLK_B) ? tick_b : 1'b0;
      wire hit = wr && ch_sel && (ch_idx == c);

      pwm_channel_core u_core (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(ch_en[c]),
        .start_i(start[c]),
        .tick_i(tick),
        .align_i(ch_mode[c][`CM_ALIGN_BIT]),
        .pol_i(ch_mode[c][`CM_POL_BIT]),
        .duty_i(ch_duty[c]),
        .period_i(ch_period[c]),
        .count_o(cnt_w[c]),
        .period_end_o(period_end[c]),
        .wave_o(pwm_o[c])
      );

      always @(posedge clk_i) begin
        if (rst_i) begin
          ch_mode[c] <= {`CM_WIDTH{1'b0}};
          ch_duty[c] <= {`CNT_W{1'b0}};
          ch_period[c] <= {`CNT_W{1'b0}};
          ch_upd[c] <= {`CNT_W{1'b0}};
          upd_pend[c] <= 1'b0;
        end else begin
          if (hit && ch_ofs == `OFS_CH_MODE) begin
            ch_mode[c] <= wdat[`CM_WIDTH-1:0];
          end
          if (hit && ch_ofs == `OFS_CH_DUTY) begin
            ch_duty[c] <= wdat[`CNT_W-1:0];
          end
          if (hit && ch_ofs == `OFS_CH_PERIOD) begin
            ch_period[c] <= wdat[`CNT_W-1:0];
          end
          if (hit && ch_ofs == `OFS_CH_UPDATE) begin
            ch_upd[c] <= wdat[`CNT_W-1:0];
            upd_pend[c] <= 1'b1;
          end else if (period_end[c] && upd_pend[c]) begin
            upd_pend[c] <= 1'b0;
            if (ch_mode[c][`CM_UPD_BIT]) begin
              ch_period[c] <= ch_upd[c];
            end else begin
              ch_duty[c] <= ch_upd[c];
            end
          end
        end
      end
    end
  endgenerate

  // Global control and status
  always @(posedge clk_i) begin
    if (rst_i) begin
      global_mode <= `RESET_WORD;
      ch_en <= {`NUM_CH{1'b0}};
      irq_mask <= {`NUM_CH{1'b0}};
      irq_flag <= {`NUM_CH{1'b0}};
    end else begin
      if (wr && adr_i == `ADDR_MODE_GLOBAL) begin
        global_mode <= (global_mode & ~wmask) | wdat;
      end
      if (wr && adr_i == `ADDR_OUT_ENABLE) begin
        ch_en <= ch_en | wdat[`NUM_CH-1:0];
      end
      if (wr && adr_i == `ADDR_OUT_DISABLE) begin
        ch_en <= ch_en & ~wdat[`NUM_CH-1:0];
      end
      if (wr && adr_i == `ADDR_IRQ_ENABLE) begin
        irq_mask <= irq_mask | wdat[`NUM_CH-1:0];
      end
      if (wr && adr_i == `ADDR_IRQ_DISABLE) begin
        irq_mask <= irq_mask & ~wdat[`NUM_CH-1:0];
      end
      // Read clears, but a period end in the same cycle survives
      if (rd && adr_i == `ADDR_IRQ_STATUS) begin
        irq_flag <= period_end;
      end else begin
        irq_flag <= irq_flag | period_end;
      end
    end
  end

  assign irq_o = |(irq_flag & irq_mask);

  // Read mux
  always @* begin
    next_dat = 32'h0000_0000;
    if (ch_sel) begin
      case (ch_ofs)
        `OFS_CH_MODE: next_dat[`CM_WIDTH-1:0] = ch_mode[ch_idx];
        `OFS_CH_DUTY: next_dat[`CNT_W-1:0] = ch_duty[ch_idx];
        `OFS_CH_PERIOD: next_dat[`CNT_W-1:0] = ch_period[ch_idx];
        `OFS_CH_COUNT: next_dat[`CNT_W-1:0] = cnt_w[ch_idx];
        default: next_dat = 32'h0000_0000;
      endcase
    end else begin
      case (adr_i)
        `ADDR_MODE_GLOBAL: next_dat = global_mode;
        `ADDR_OUT_STATUS: next_dat[`NUM_CH-1:0] = ch_en;
        `ADDR_IRQ_MASK: next_dat[`NUM_CH-1:0] = irq_mask;
        `ADDR_IRQ_STATUS: next_dat[`NUM_CH-1:0] = irq_flag;
        default: next_dat = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      dat_o <= rd ? next_dat : 32'h0000_0000;
    end
  end

endmodule

/* File: logic/pwm_channel_core.v */
`timescale 1ns/1ps
`include "pwm_ctrl_map.vh"

module pwm_channel_core (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Control
  input wire enable_i,
  input wire start_i,
  input wire tick_i,
  input wire align_i,
  input wire pol_i,
  input wire [`CNT_W-1:0] duty_i,
  input wire [`CNT_W-1:0] period_i,
  // Status
  output reg [`CNT_W-1:0] count_o,
  output wire period_end_o,
  output reg wave_o
);

  reg down;
  wire [`CNT_W-1:0] top;
  wire at_top;
  wire at_zero;

  // Centre aligned turns at the period value, so a period is twice that
  assign top = align_i ? period_i :
    (period_i == {`CNT_W{1'b0}}) ? period_i : period_i - 16'h0001;
  assign at_top = (count_o >= top);
  assign at_zero = (count_o == {`CNT_W{1'b0}});
  // Centre aligned ends when counting down reaches zero
  assign period_end_o = enable_i && tick_i &&
    (align_i ? (down && at_zero) : at_top);

  always @(posedge clk_i) begin
    if (rst_i || start_i) begin
      count_o <= {`CNT_W{1'b0}};
      down <= 1'b0;
    end else if (enable_i && tick_i) begin
      if (!align_i) begin
        count_o <= at_top ? {`CNT_W{1'b0}} : count_o + 16'h0001;
        down <= 1'b0;
      end else if (!down) begin
        if (at_top) begin
          down <= 1'b1;
          count_o <= (top == {`CNT_W{1'b0}}) ? count_o :
            count_o - 16'h0001;
        end else begin
          count_o <= count_o + 16'h0001;
        end
      end else begin
        if (at_zero) begin
          down <= 1'b0;
          count_o <= count_o + 16'h0001;
        end else begin
          count_o <= count_o - 16'h0001;
        end
      end
    end
  end

  // Start level while the count is below duty, the other level while it is at or above duty
  always @(posedge clk_i) begin
    if (rst_i) begin
      wave_o <= 1'b0;
    end else if (!enable_i) begin
      wave_o <= 1'b0;
    end else begin
      wave_o <= (count_o < duty_i) ? pol_i : ~pol_i;
    end
  end

endmodule

/* File: pkg/pwm_ctrl_map.vh */
`ifndef PWM_CTRL_MAP_VH
`define PWM_CTRL_MAP_VH

// Global register byte offsets
`define ADDR_MODE_GLOBAL 12'h000
`define ADDR_OUT_ENABLE 12'h004
`define ADDR_OUT_DISABLE 12'h008
`define ADDR_OUT_STATUS 12'h00c
`define ADDR_IRQ_ENABLE 12'h010
`define ADDR_IRQ_DISABLE 12'h014
`define ADDR_IRQ_MASK 12'h018
`define ADDR_IRQ_STATUS 12'h01c

// Channel block: base plus channel times stride
`define ADDR_CH_BASE 12'h200
`define CH_STRIDE_BIT 5
`define OFS_CH_MODE 3'h0
`define OFS_CH_DUTY 3'h1
`define OFS_CH_PERIOD 3'h2
`define OFS_CH_COUNT 3'h3
`define OFS_CH_UPDATE 3'h4

// Global mode fields
`define GM_DIVA_LSB 0
`define GM_PREA_LSB 8
`define GM_DIVB_LSB 16
`define GM_PREB_LSB 24

// Channel mode fields
`define CM_PRE_LSB 0
`define CM_ALIGN_BIT 8
`define CM_POL_BIT 9
`define CM_UPD_BIT 10
`define CM_WIDTH 11

// Prescaler codes
`define PRE_MAX_POW 4'ha
`define PRE_CLK_A 4'hb
`define PRE_CLK_B 4'hc

// Sizes
`define NUM_CH 4
`define CNT_W 16
`define RESET_WORD 32'h0000_0000

`endif

/* File: tb/pwm_channel_control_regs_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    n_checks++; \
    if ((g) !== (e)) begin \
      mismatches++; \
      $display("[FAIL] t=%0t got %0h exp %0h", $time, g, e); \
    end \
  end
module pwm_channel_control_regs_tb;
  reg clk_i = 0;
  reg rst_i = 1;
  reg cyc_i = 0;
  reg stb_i = 0;
  reg we_i = 0;
  reg [11:0] adr_i = 12'h000;
  reg [3:0] sel_i = 4'hf;
  reg [31:0] dat_i = 32'h0;
  wire [31:0] dat_o;
  wire ack_o;
  wire [3:0] pwm_o;
  wire irq_o;
  int mismatches = 0;
  int n_checks = 0;
  int per;
  int hi;
  logic [31:0] rdat;
  pwm_channel_control_regs uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .pwm_o(pwm_o), .irq_o(irq_o));
  initial forever #5 clk_i = ~clk_i;
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One classic bus cycle, held until ack is sampled
  task xfer(input bit w, input [11:0] a, input [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rdat = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task rdc(input [11:0] a, input [31:0] e);
    xfer(0, a, 0);
    `CHK(rdat, e)
  endtask
  // Period and high time of channel 0, from one rising edge to the next
  task meas;
    per = 0;
    hi = 0;
    while (pwm_o[0] !== 1'b0 && per < 9000) @(posedge clk_i) per++;
    while (pwm_o[0] !== 1'b1 && per < 9000) @(posedge clk_i) per++;
    per = 0;
    while (pwm_o[0] === 1'b1 && per < 9000) @(posedge clk_i) begin
      hi++;
      per++;
    end
    while (pwm_o[0] !== 1'b1 && per < 9000) @(posedge clk_i) per++;
  endtask
  task run(input [31:0] m, input int ep, input int eh);
    xfer(1, 12'h008, 32'h1);
    xfer(1, 12'h200, m);
    xfer(1, 12'h004, 32'h1);
    meas();
    `CHK(per, ep)
    if (eh >= 0) `CHK(hi, eh)
  endtask
  initial begin
    #1_000_000;
    mismatches++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(12'h00c, 0);
    rdc(12'h018, 0);
    rdc(12'h01c, 0);
    $display("test reset done");
    xfer(1, 12'h004, 32'h5);
    rdc(12'h00c, 32'h5);
    xfer(1, 12'h004, 32'h0);
    rdc(12'h00c, 32'h5);
    xfer(1, 12'h008, 32'hffff_fff1);
    rdc(12'h00c, 32'h4);
    xfer(1, 12'h004, 32'hffff_fff8);
    rdc(12'h00c, 32'hc);
    xfer(1, 12'h008, 32'hf);
    xfer(1, 12'h010, 32'hb);
    rdc(12'h018, 32'hb);
    xfer(1, 12'h014, 32'h3);
    rdc(12'h018, 32'h8);
    xfer(1, 12'h100, 32'hffff_ffff);
    rdc(12'h100, 0);
    rdc(12'h22c, 0);
    $display("test control done");
    for (int c = 0; c < 4; c++) begin
      xfer(1, 12'(12'h200 + c * 32), 32'hffff_ffff);
      rdc(12'(12'h200 + c * 32), 32'h7ff);
      xfer(1, 12'(12'h204 + c * 32), 32'habcd_0000 + c);
      rdc(12'(12'h204 + c * 32), c);
    end
    xfer(1, 12'h204, 32'h1);
    xfer(1, 12'h208, 32'h4);
    xfer(1, 12'h000, 32'h0103_0002);
    for (int c = 0; c <= 10; c++) run(c, 4 << c, 3 << c);
    run(32'hb, 8, 6);
    run(32'hc, 24, 18);
    run(32'h200, 4, 1);
    run(32'h100, 8, -1);
    run(32'h0, 4, 3);
    $display("test waveform done");
    xfer(1, 12'h210, 32'h3);
    repeat (12) @(posedge clk_i);
    rdc(12'h204, 32'h3);
    meas();
    `CHK(hi, 1)
    xfer(1, 12'h200, 32'h400);
    xfer(1, 12'h210, 32'h6);
    repeat (16) @(posedge clk_i);
    rdc(12'h208, 32'h6);
    meas();
    `CHK(per, 6)
    $display("test update done");
    xfer(1, 12'h008, 32'hf);
    xfer(0, 12'h01c, 0);
    xfer(1, 12'h004, 32'h1);
    xfer(1, 12'h010, 32'h1);
    repeat (10) @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    xfer(1, 12'h008, 32'h1);
    rdc(12'h01c, 32'h1);
    rdc(12'h01c, 32'h0);
    `CHK(irq_o, 1'b0)
    xfer(1, 12'h004, 32'h1);
    xfer(1, 12'h014, 32'hf);
    repeat (10) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    $display("test interrupt done");
    summarize();
  end
endmodule

/* File: tb/pwm_regs_checker.sv */
`timescale 1ns/1ps
module pwm_regs_checker (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Bus
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [11:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  // Waveforms and interrupt
  input wire [3:0] pwm_o,
  input wire irq_o
);
  reg [3:0] en;
  reg [3:0] msk;
  wire wr = cyc_i & stb_i & ~ack_o & we_i & sel_i[0];
  wire rd = ack_o & ~we_i;
  // Shadow of the enable and mask state
  always @(posedge clk_i) begin
    if (rst_i) begin
      en <= 4'h0;
      msk <= 4'h0;
    end else if (wr) begin
      case (adr_i)
        12'h004: en <= en | dat_i[3:0];
        12'h008: en <= en & ~dat_i[3:0];
        12'h010: msk <= msk | dat_i[3:0];
        12'h014: msk <= msk & ~dat_i[3:0];
        default: ;
      endcase
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_delay_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");
  out_status_a: assert property (rd && adr_i == 12'h00c |->
    dat_o == {28'h0, en}) else $error("output status wrong");
  pwm_off_a: assert property (
    (pwm_o & ~(en | $past(en) | $past(en, 2))) == 4'h0)
    else $error("waveform on a disabled channel");
  mask_read_a: assert property (rd && adr_i == 12'h018 |->
    dat_o == {28'h0, msk}) else $error("irq mask wrong");
  irq_masked_a: assert property (irq_o |-> msk != 4'h0)
    else $error("irq with all channels masked");
  isr_resv_a: assert property (rd && adr_i == 12'h01c |->
    dat_o[31:4] == 28'h0) else $error("irq status upper bits set");
  mode_resv_a: assert property ((adr_i & 12'hf9f) == 12'h200 && rd |->
    dat_o[31:11] == 21'h0) else $error("mode upper bits set");
  duty_width_a: assert property ((adr_i & 12'hf9f) == 12'h204 && rd |->
    dat_o[31:16] == 16'h0) else $error("duty upper bits set");
  unmapped_a: assert property (rd && adr_i >= 12'h020 &&
    adr_i < 12'h200 |-> dat_o == 32'h0) else $error("unmapped read nonzero");
endmodule
bind pwm_channel_control_regs pwm_regs_checker chk (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .pwm_o(pwm_o), .irq_o(irq_o));
